// file: hdl/hvrb_consts.vh
// Constants for the air-conditioning unit supervisor register bank.
`ifndef HVRB_CONSTS_VH
`define HVRB_CONSTS_VH

`define HVRB_FN_WRITE_SINGLE     8'h06
`define HVRB_FN_WRITE_MULTI      8'h10

`define HVRB_ADR_CTRL_EN         16'h0065
`define HVRB_ADR_COMP_REQ        16'h0066
`define HVRB_ADR_HEAT_REQ        16'h0067
`define HVRB_ADR_REMOTE_ONOFF    16'h0068
`define HVRB_ADR_FAN_BEHAV       16'h0069
`define HVRB_ADR_VALVE_MODE      16'h006a
`define HVRB_ADR_DEMAND_LIMIT    16'h006b
`define HVRB_ADR_FAN_SPD_REQ     16'h006c
`define HVRB_ADR_CAP_REQ         16'h006d
`define HVRB_ADR_VALVE1_PCT      16'h001a
`define HVRB_ADR_VALVE2_PCT      16'h001b
`define HVRB_ADR_MIN_RUN         16'h00c9
`define HVRB_ADR_MIN_OFF         16'h00ca
`define HVRB_ADR_START_INT       16'h00cb
`define HVRB_ADR_TO_COOL         16'h00d8
`define HVRB_ADR_TO_HEAT         16'h00d9
`define HVRB_ADR_OUT_FAN_OUT     16'h0191
`define HVRB_ADR_IN_FAN_OUT      16'h0192
`define HVRB_ADR_VALVE1_POS      16'h0193
`define HVRB_ADR_VALVE2_POS      16'h0194
`define HVRB_ADR_CAP_OUT         16'h0195
`define HVRB_ADR_RELAYS          16'h0196
`define HVRB_ADR_OP_STATE        16'h0197

`define HVRB_EN_COMP             0
`define HVRB_EN_HEAT             1
`define HVRB_EN_FAN_MODE         3
`define HVRB_EN_FAN_SPEED        6
`define HVRB_EN_CAPACITY         7
`define HVRB_EN_MASK             16'h00cb

`define HVRB_RST_CTRL_EN         16'h0000
`define HVRB_RST_COMP            16'h0000
`define HVRB_RST_HEAT            16'h0000
`define HVRB_RST_FAN_BEHAV       16'h0000
`define HVRB_RST_FAN_SPEED       16'h0000
`define HVRB_RST_CAPACITY        16'h0032

`define HVRB_FAN_BEHAV_MASK      16'h000f
`define HVRB_RELAY_MASK          16'h01ff
`define HVRB_STATE_MASK          16'h000f
`define HVRB_SPEED_MAX           16'h03e8
`define HVRB_CAP_OUT_MAX         16'h03e8
`define HVRB_PCT_MAX             16'h0064
`define HVRB_VALVE_FULL_DEF      16'h01e0

`define HVRB_CLK_PERIOD_NS       4
`define HVRB_SECOND_NS           1000000000
`define HVRB_MIN_RUN_S           16'h00b4
`define HVRB_MIN_OFF_S           16'h00b4
`define HVRB_START_INT_S         16'h0168
`define HVRB_HOLDOFF_S           16'h00b4

`endif

// file: hdl/hvrb_register_bank.v
// Supervisor register bank with compressor safety timers and control hand-over.
`timescale 1ns/100ps
`include "hvrb_consts.vh"

// Functional notes
// - Enable bits hand five signals to supervisor.
// - Fan behaviour bits: fixed, deadband, de-ice, heatstart.
// - Protection may override supervisor fan behaviour.
// - Fan speed register is speed request.
// - Capacity register requests percent of maximum.
// - Writing 1 requests compressor start.
// - Writes accepted by function 6 and 16.
// - Nonzero safety timer holds compressor state.
// - Run, off, start-interval timers at 201-203.
// - Heat/cool change hold-off timers at 216/217.
// - Fan speed outputs report 0 to 1000.
// - Valve positions report 0 to full count.
// - Capacity output reports 0 to 1000.
// - Relay output bit map as documented.
// - Unit mode reports codes 0 to 12.
// - Valve openings also reported as percent.
// - Enabled bit removes control from other sources.
// - Enable bits clear at power loss.
// - Heat/cool: 0 cooling, 1 heating.
module hvrb_register_bank #(
    parameter SEC_CYCLES = `HVRB_SECOND_NS / `HVRB_CLK_PERIOD_NS,
    parameter [15:0] VALVE_FULL  = `HVRB_VALVE_FULL_DEF,
    parameter [15:0] MIN_RUN_S   = `HVRB_MIN_RUN_S,
    parameter [15:0] MIN_OFF_S   = `HVRB_MIN_OFF_S,
    parameter [15:0] START_INT_S = `HVRB_START_INT_S,
    parameter [15:0] HOLDOFF_S   = `HVRB_HOLDOFF_S
) (
    input  wire        ref_clk_i,          // System clock.
    input  wire        rst_i,              // Asynchronous reset, power loss.
    input  wire        ce_i,               // Clock enable.
    input  wire [15:0] reg_addr_i,         // Register address.
    input  wire [7:0]  reg_fn_i,           // Function code of the access.
    input  wire [15:0] reg_wdata_i,        // Write data.
    input  wire        reg_wr_i,           // Write strobe, one word.
    input  wire        reg_rd_i,           // Read strobe, one word.
    output reg  [15:0] reg_rdata_o,        // Read data.
    output reg         reg_ack_o,          // Access accepted.
    output reg         reg_err_o,          // Access refused.
    input  wire        local_comp_i,       // Local compressor request.
    input  wire        local_heat_i,       // Local heat request.
    input  wire [3:0]  local_fan_behav_i,  // Local fan behaviour.
    input  wire [15:0] local_fan_speed_i,  // Local fan speed request.
    input  wire [15:0] local_capacity_i,   // Local capacity request.
    input  wire        protect_fan_i,      // Protection takes the fan.
    input  wire [15:0] out_fan_speed_i,    // Outdoor fan speed.
    input  wire [15:0] in_fan_speed_i,     // Indoor fan speed.
    input  wire [15:0] valve1_pos_i,       // Valve 1 position.
    input  wire [15:0] valve2_pos_i,       // Valve 2 position.
    input  wire [15:0] capacity_i,         // Unit capacity.
    input  wire [8:0]  relays_i,           // Relay output states.
    input  wire [3:0]  op_state_i,         // Unit operating mode code.
    output reg         comp_cmd_o,         // Compressor running command.
    output reg         heat_cmd_o,         // 1 heating, 0 cooling.
    output reg  [3:0]  fan_behav_o,        // Effective fan behaviour.
    output reg  [15:0] fan_speed_o,        // Effective fan speed request.
    output reg  [15:0] capacity_pct_o      // Effective capacity percent.
);

    reg  [15:0] ctrl_en_r;
    reg  [15:0] comp_req_r;
    reg  [15:0] heat_req_r;
    reg  [15:0] fan_behav_r;
    reg  [15:0] fan_spd_req_r;
    reg  [15:0] cap_req_r;
    reg  [15:0] min_run_r;
    reg  [15:0] min_off_r;
    reg  [15:0] start_int_r;
    reg  [15:0] to_cool_r;
    reg  [15:0] to_heat_r;
    reg  [15:0] out_fan_r;
    reg  [15:0] in_fan_r;
    reg  [15:0] valve1_r;
    reg  [15:0] valve2_r;
    reg  [15:0] cap_out_r;
    reg  [15:0] relays_r;
    reg  [15:0] state_r;
    reg  [15:0] valve1_pct_r;
    reg  [15:0] valve2_pct_r;
    reg  [31:0] sec_cnt_r;
    reg         sec_tick_r;
    reg  [15:0] rdata_nxt;
    reg         hit_nxt;

    wire        wr_fn_ok = (reg_fn_i == `HVRB_FN_WRITE_SINGLE) ||
                           (reg_fn_i == `HVRB_FN_WRITE_MULTI);
    wire [15:0] v1_clip  = (valve1_pos_i > VALVE_FULL) ? VALVE_FULL : valve1_pos_i;
    wire [15:0] v2_clip  = (valve2_pos_i > VALVE_FULL) ? VALVE_FULL : valve2_pos_i;
    wire [31:0] v1_mul   = {16'h0000, v1_clip} * {16'h0000, `HVRB_PCT_MAX};
    wire [31:0] v2_mul   = {16'h0000, v2_clip} * {16'h0000, `HVRB_PCT_MAX};
    wire [31:0] v1_div   = v1_mul / {16'h0000, VALVE_FULL};
    wire [31:0] v2_div   = v2_mul / {16'h0000, VALVE_FULL};

    // Selected request per signal: the supervisor once its bit is set, else local.
    wire        comp_sel = ctrl_en_r[`HVRB_EN_COMP] ? comp_req_r[0] : local_comp_i;
    wire        heat_sel = ctrl_en_r[`HVRB_EN_HEAT] ? heat_req_r[0] : local_heat_i;
    wire [3:0]  fanb_sel = ctrl_en_r[`HVRB_EN_FAN_MODE] ? fan_behav_r[3:0] : local_fan_behav_i;
    wire [15:0] fans_sel = ctrl_en_r[`HVRB_EN_FAN_SPEED] ? fan_spd_req_r : local_fan_speed_i;
    wire [15:0] cap_sel  = ctrl_en_r[`HVRB_EN_CAPACITY] ? cap_req_r : local_capacity_i;

    wire        may_start = (min_off_r == 16'h0000) && (start_int_r == 16'h0000);
    wire        may_stop  = (min_run_r == 16'h0000);
    wire        to_heat_ok = (to_heat_r == 16'h0000);
    wire        to_cool_ok = (to_cool_r == 16'h0000);

    always @* begin
        rdata_nxt = 16'h0000;
        hit_nxt   = 1'b1;
        case (reg_addr_i)
            `HVRB_ADR_CTRL_EN:      rdata_nxt = ctrl_en_r;
            `HVRB_ADR_COMP_REQ:     rdata_nxt = comp_req_r;
            `HVRB_ADR_HEAT_REQ:     rdata_nxt = heat_req_r;
            `HVRB_ADR_FAN_BEHAV:    rdata_nxt = fan_behav_r;
            `HVRB_ADR_FAN_SPD_REQ:  rdata_nxt = fan_spd_req_r;
            `HVRB_ADR_CAP_REQ:      rdata_nxt = cap_req_r;
            `HVRB_ADR_REMOTE_ONOFF: rdata_nxt = 16'h0000;
            `HVRB_ADR_VALVE_MODE:   rdata_nxt = 16'h0000;
            `HVRB_ADR_DEMAND_LIMIT: rdata_nxt = 16'h0000;
            `HVRB_ADR_VALVE1_PCT:   rdata_nxt = valve1_pct_r;
            `HVRB_ADR_VALVE2_PCT:   rdata_nxt = valve2_pct_r;
            `HVRB_ADR_MIN_RUN:      rdata_nxt = min_run_r;
            `HVRB_ADR_MIN_OFF:      rdata_nxt = min_off_r;
            `HVRB_ADR_START_INT:    rdata_nxt = start_int_r;
            `HVRB_ADR_TO_COOL:      rdata_nxt = to_cool_r;
            `HVRB_ADR_TO_HEAT:      rdata_nxt = to_heat_r;
            `HVRB_ADR_OUT_FAN_OUT:  rdata_nxt = out_fan_r;
            `HVRB_ADR_IN_FAN_OUT:   rdata_nxt = in_fan_r;
            `HVRB_ADR_VALVE1_POS:   rdata_nxt = valve1_r;
            `HVRB_ADR_VALVE2_POS:   rdata_nxt = valve2_r;
            `HVRB_ADR_CAP_OUT:      rdata_nxt = cap_out_r;
            `HVRB_ADR_RELAYS:       rdata_nxt = relays_r;
            `HVRB_ADR_OP_STATE:     rdata_nxt = state_r;
            default:                hit_nxt   = 1'b0;
        endcase
    end

    // Only the control block accepts writes; read-only words answer with an error.
    wire wr_ctrl = (reg_addr_i >= `HVRB_ADR_CTRL_EN) && (reg_addr_i <= `HVRB_ADR_CAP_REQ);

    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= 16'h0000;
            reg_ack_o   <= 1'b0;
            reg_err_o   <= 1'b0;
        end else if (ce_i) begin
            reg_ack_o <= 1'b0;
            reg_err_o <= 1'b0;
            if (reg_wr_i) begin
                reg_ack_o <= wr_ctrl && wr_fn_ok;
                reg_err_o <= !(wr_ctrl && wr_fn_ok);
            end else if (reg_rd_i) begin
                reg_rdata_o <= rdata_nxt;
                reg_ack_o   <= hit_nxt;
                reg_err_o   <= !hit_nxt;
            end
        end
    end

    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_en_r     <= `HVRB_RST_CTRL_EN;
            comp_req_r    <= `HVRB_RST_COMP;
            heat_req_r    <= `HVRB_RST_HEAT;
            fan_behav_r   <= `HVRB_RST_FAN_BEHAV;
            fan_spd_req_r <= `HVRB_RST_FAN_SPEED;
            cap_req_r     <= `HVRB_RST_CAPACITY;
        end else if (ce_i && reg_wr_i && wr_fn_ok) begin
            case (reg_addr_i)
                `HVRB_ADR_CTRL_EN:     ctrl_en_r     <= reg_wdata_i & `HVRB_EN_MASK;
                `HVRB_ADR_COMP_REQ:    comp_req_r    <= reg_wdata_i;
                `HVRB_ADR_HEAT_REQ:    heat_req_r    <= reg_wdata_i;
                `HVRB_ADR_FAN_BEHAV:   fan_behav_r   <= reg_wdata_i & `HVRB_FAN_BEHAV_MASK;
                `HVRB_ADR_FAN_SPD_REQ: fan_spd_req_r <= reg_wdata_i;
                `HVRB_ADR_CAP_REQ:     cap_req_r     <= reg_wdata_i;
                default:               cap_req_r     <= cap_req_r;
            endcase
        end
    end

    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sec_cnt_r  <= 32'h00000000;
            sec_tick_r <= 1'b0;
        end else if (ce_i) begin
            sec_tick_r <= 1'b0;
            if (sec_cnt_r >= SEC_CYCLES - 1) begin
                sec_cnt_r  <= 32'h00000000;
                sec_tick_r <= 1'b1;
            end else begin
                sec_cnt_r <= sec_cnt_r + 32'h00000001;
            end
        end
    end

    // Compressor and heat/cool sequencing; a running timer blocks only the change it guards.
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            comp_cmd_o  <= 1'b0;
            heat_cmd_o  <= 1'b0;
            min_run_r   <= 16'h0000;
            min_off_r   <= 16'h0000;
            start_int_r <= 16'h0000;
            to_cool_r   <= 16'h0000;
            to_heat_r   <= 16'h0000;
        end else if (ce_i) begin
            if (sec_tick_r && min_run_r != 16'h0000)
                min_run_r <= min_run_r - 16'h0001;
            if (sec_tick_r && min_off_r != 16'h0000)
                min_off_r <= min_off_r - 16'h0001;
            if (sec_tick_r && start_int_r != 16'h0000)
                start_int_r <= start_int_r - 16'h0001;
            if (sec_tick_r && to_cool_r != 16'h0000)
                to_cool_r <= to_cool_r - 16'h0001;
            if (sec_tick_r && to_heat_r != 16'h0000)
                to_heat_r <= to_heat_r - 16'h0001;
            if (!comp_cmd_o && comp_sel && may_start) begin
                comp_cmd_o  <= 1'b1;
                min_run_r   <= MIN_RUN_S;
                start_int_r <= START_INT_S;
            end else if (comp_cmd_o && !comp_sel && may_stop) begin
                comp_cmd_o <= 1'b0;
                min_off_r  <= MIN_OFF_S;
            end
            if (!heat_cmd_o && heat_sel && to_heat_ok) begin
                heat_cmd_o <= 1'b1;
                to_cool_r  <= HOLDOFF_S;
            end else if (heat_cmd_o && !heat_sel && to_cool_ok) begin
                heat_cmd_o <= 1'b0;
                to_heat_r  <= HOLDOFF_S;
            end
        end
    end

    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            fan_behav_o    <= 4'h0;
            fan_speed_o    <= 16'h0000;
            capacity_pct_o <= 16'h0000;
            out_fan_r      <= 16'h0000;
            in_fan_r       <= 16'h0000;
            valve1_r       <= 16'h0000;
            valve2_r       <= 16'h0000;
            cap_out_r      <= 16'h0000;
            relays_r       <= 16'h0000;
            state_r        <= 16'h0000;
            valve1_pct_r   <= 16'h0000;
            valve2_pct_r   <= 16'h0000;
        end else if (ce_i) begin
            fan_behav_o    <= protect_fan_i ? local_fan_behav_i : fanb_sel;
            fan_speed_o    <= protect_fan_i ? local_fan_speed_i : fans_sel;
            capacity_pct_o <= (cap_sel > `HVRB_PCT_MAX) ? `HVRB_PCT_MAX : cap_sel;
            out_fan_r <= (out_fan_speed_i > `HVRB_SPEED_MAX) ? `HVRB_SPEED_MAX : out_fan_speed_i;
            in_fan_r  <= (in_fan_speed_i > `HVRB_SPEED_MAX) ? `HVRB_SPEED_MAX : in_fan_speed_i;
            valve1_r  <= v1_clip;
            valve2_r  <= v2_clip;
            cap_out_r <= (capacity_i > `HVRB_CAP_OUT_MAX) ? `HVRB_CAP_OUT_MAX : capacity_i;
            relays_r  <= {7'h00, relays_i} & `HVRB_RELAY_MASK;
            state_r   <= {12'h000, op_state_i} & `HVRB_STATE_MASK;
            valve1_pct_r <= v1_div[15:0];
            valve2_pct_r <= v2_div[15:0];
        end
    end

endmodule // hvrb_register_bank

// file: tb/hvrb_checker_asserts.sv
// Port checker for the supervisor register bank.
`timescale 1ns/100ps
`include "hvrb_consts.vh"
module hvrb_checker #(
    parameter        SEC_CYCLES = 4,
    parameter [15:0] MIN_RUN_S  = 16'h0003
) (
    input wire        ref_clk_i,         // Clock.
    input wire        rst_i,             // Reset.
    input wire        ce_i,              // Clock enable.
    input wire [15:0] reg_addr_i,        // Address.
    input wire [7:0]  reg_fn_i,          // Function code.
    input wire        reg_wr_i,          // Write strobe.
    input wire        reg_rd_i,          // Read strobe.
    input wire [15:0] reg_rdata_o,       // Read data.
    input wire        reg_ack_o,         // Accepted.
    input wire        reg_err_o,         // Refused.
    input wire [3:0]  local_fan_behav_i, // Local fan behaviour.
    input wire        protect_fan_i,     // Protection.
    input wire [3:0]  op_state_i,        // Mode code.
    input wire        comp_cmd_o,        // Compressor.
    input wire [3:0]  fan_behav_o,       // Fan behaviour.
    input wire [15:0] capacity_pct_o     // Capacity.
);
    wire rd_only = ce_i && reg_rd_i && !reg_wr_i;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    acc_answer_a: assert property ((reg_wr_i || reg_rd_i) && ce_i |=> reg_ack_o != reg_err_o)
        else $error("access answer is not exactly one of ack and err");
    idle_quiet_a: assert property (ce_i && !reg_wr_i && !reg_rd_i |=> !reg_ack_o && !reg_err_o)
        else $error("answer without a request");
    bad_fn_a: assert property (ce_i && reg_wr_i && reg_fn_i != 8'h06 && reg_fn_i != 8'h10 |=> reg_err_o)
        else $error("write with a foreign function code accepted");
    ro_write_a: assert property (ce_i && reg_wr_i && reg_addr_i >= `HVRB_ADR_MIN_RUN |=> reg_err_o)
        else $error("write to a read-only place accepted");
    relay_mask_a: assert property (rd_only && reg_addr_i == `HVRB_ADR_RELAYS
        |=> (reg_rdata_o & ~`HVRB_RELAY_MASK) == 16'h0000)
        else $error("relay word carries reserved bits");
    state_pass_a: assert property (rd_only && reg_addr_i == `HVRB_ADR_OP_STATE
        |=> reg_rdata_o == {12'h000, $past(op_state_i, 2)})
        else $error("mode code read back wrongly");
    pct_range_a: assert property (capacity_pct_o <= `HVRB_PCT_MAX)
        else $error("capacity request above one hundred");
    protect_fan_a: assert property (ce_i && protect_fan_i |=> fan_behav_o == $past(local_fan_behav_i))
        else $error("protection did not take the fan");
    // Eight cycles holds while MIN_RUN_S minus one, times SEC_CYCLES, is at least six.
    comp_hold_a: assert property ($rose(comp_cmd_o) |-> comp_cmd_o [*8])
        else $error("compressor stopped inside its minimum run");
    reset_clear_a: assert property ($fell(rst_i) |-> !comp_cmd_o && capacity_pct_o == 16'h0000)
        else $error("outputs not cleared by reset");
    cover property (reg_err_o);
    cover property ($rose(comp_cmd_o));
    cover property (ce_i && protect_fan_i);
endmodule // hvrb_checker

bind hvrb_register_bank hvrb_checker #(.SEC_CYCLES(SEC_CYCLES), .MIN_RUN_S(MIN_RUN_S)) chk_u (
    .ref_clk_i, .rst_i, .ce_i, .reg_addr_i, .reg_fn_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .reg_ack_o,
    .reg_err_o, .local_fan_behav_i, .protect_fan_i, .op_state_i, .comp_cmd_o, .fan_behav_o, .capacity_pct_o);

// file: tb/hvrb_supervisor.sv
// Building supervisor model that issues register accesses one word at a time.
`timescale 1ns/100ps
module hvrb_supervisor (
    input  wire         ref_clk_i,   // Clock.
    input  wire  [15:0] reg_rdata_o, // Read data.
    input  wire         reg_ack_o,   // Accepted.
    input  wire         reg_err_o,   // Refused.
    output logic [15:0] reg_addr_i,  // Address.
    output logic [7:0]  reg_fn_i,    // Function code.
    output logic [15:0] reg_wdata_i, // Write data.
    output logic        reg_wr_i,    // Write strobe.
    output logic        reg_rd_i     // Read strobe.
);
    logic [15:0] q;
    logic        ok;
    logic        bad;
    initial begin
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        reg_addr_i = 16'h0000;
        reg_fn_i = 8'h00;
        reg_wdata_i = 16'h0000;
    end
    // Released address and data show the inverse of the last word.
    task access(input logic w, input logic [15:0] a, input logic [15:0] d, input logic [7:0] f);
        @(posedge ref_clk_i);
        reg_wr_i <= w;
        reg_rd_i <= !w;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_fn_i <= f;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
        reg_addr_i <= ~a;
        reg_wdata_i <= ~d;
        #1;
        q = reg_rdata_o;
        ok = reg_ack_o;
        bad = reg_err_o;
    endtask
    // Unused words get the recommended remote and limit values; valve mode gets a random 0 to 3.
    task block_write(input logic [15:0] en, cmp, ht, fb, sp, cp, output int n_ok);
        logic [15:0] v [0:8];
        int k;
        v = '{en, cmp, ht, 16'h0001, fb, 16'($urandom_range(3)), 16'h0000, sp, cp};
        n_ok = 0;
        for (k = 0; k < 9; k++) begin
            access(1'b1, 16'h0065 + 16'(k), v[k], 8'h10);
            n_ok += int'(ok === 1'b1);
        end
    endtask
endmodule // hvrb_supervisor

// file: tb/tb.sv
// Self-checking bench for the supervisor register bank.
`timescale 1ns/100ps
`include "hvrb_consts.vh"
module tb;
    localparam [15:0] HOLD_S = 16'h0002;
    logic        ref_clk_i, rst_i, ce_i, reg_wr_i, reg_rd_i, reg_ack_o, reg_err_o, local_comp_i, local_heat_i;
    logic        protect_fan_i, comp_cmd_o, heat_cmd_o;
    logic [15:0] reg_addr_i, reg_wdata_i, reg_rdata_o, local_fan_speed_i, local_capacity_i, fan_speed_o;
    logic [15:0] out_fan_speed_i, in_fan_speed_i, valve1_pos_i, valve2_pos_i, capacity_i, capacity_pct_o;
    logic [7:0]  reg_fn_i;
    logic [8:0]  relays_i;
    logic [3:0]  local_fan_behav_i, op_state_i, fan_behav_o;
    int          failures, n_tests, i, n_ok;
    hvrb_register_bank #(.SEC_CYCLES(4), .MIN_RUN_S(16'h0003), .MIN_OFF_S(16'h0002), .START_INT_S(16'h0005),
        .HOLDOFF_S(HOLD_S)) dut_u (.ref_clk_i, .rst_i, .ce_i, .reg_addr_i, .reg_fn_i, .reg_wdata_i, .reg_wr_i,
        .reg_rd_i, .reg_rdata_o, .reg_ack_o, .reg_err_o, .local_comp_i, .local_heat_i, .local_fan_behav_i,
        .local_fan_speed_i, .local_capacity_i, .protect_fan_i, .out_fan_speed_i, .in_fan_speed_i, .valve1_pos_i,
        .valve2_pos_i, .capacity_i, .relays_i, .op_state_i, .comp_cmd_o, .heat_cmd_o, .fan_behav_o, .fan_speed_o,
        .capacity_pct_o);
    hvrb_supervisor sup_u (.ref_clk_i, .reg_rdata_o, .reg_ack_o, .reg_err_o, .reg_addr_i, .reg_fn_i, .reg_wdata_i,
        .reg_wr_i, .reg_rd_i);
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task ck1(input logic got, input logic exp);
        chk({15'h0000, got}, {15'h0000, exp});
    endtask
    task tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    task rd(input logic [15:0] a, input logic [15:0] exp, input logic e);
        sup_u.access(1'b0, a, 16'h0000, 8'h03);
        chk(sup_u.q, exp);
        ck1(sup_u.bad, e);
    endtask
    task wr(input logic [15:0] a, input logic [15:0] d, input logic [7:0] f, input logic e);
        sup_u.access(1'b1, a, d, f);
        ck1(sup_u.bad, e);
        ck1(sup_u.ok, !e);
    endtask
    function logic [15:0] lim(input logic [15:0] v, input logic [15:0] m);
        return (v > m) ? m : v;
    endfunction
    function logic [15:0] pct(input logic [15:0] v);
        return (lim(v, `HVRB_VALVE_FULL_DEF) * `HVRB_PCT_MAX) / `HVRB_VALVE_FULL_DEF;
    endfunction
    task final_report;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        #100000;
        failures++;
        final_report;
    end
    initial begin
        failures = 0;
        n_tests = 0;
        {rst_i, ce_i, local_heat_i, local_comp_i, protect_fan_i} = 5'b11100;
        {local_fan_behav_i, op_state_i, relays_i} = 17'h00000;
        {local_fan_speed_i, local_capacity_i} = {16'h0064, 16'h0014};
        {out_fan_speed_i, in_fan_speed_i, valve1_pos_i, valve2_pos_i, capacity_i} = 80'h0;
        i = $urandom(38770);
        tick(5);
        rst_i <= 1'b0;
        rd(`HVRB_ADR_CTRL_EN, `HVRB_RST_CTRL_EN, 1'b0);
        rd(`HVRB_ADR_CAP_REQ, `HVRB_RST_CAPACITY, 1'b0);
        $display("test reset done");
        wr(`HVRB_ADR_FAN_BEHAV, 16'h000f, `HVRB_FN_WRITE_SINGLE, 1'b0);
        wr(`HVRB_ADR_FAN_SPD_REQ, 16'h0226, `HVRB_FN_WRITE_SINGLE, 1'b0);
        wr(`HVRB_ADR_CAP_REQ, 16'h0046, `HVRB_FN_WRITE_SINGLE, 1'b0);
        wr(`HVRB_ADR_HEAT_REQ, 16'h0000, `HVRB_FN_WRITE_SINGLE, 1'b0);
        wr(`HVRB_ADR_COMP_REQ, 16'h0001, `HVRB_FN_WRITE_SINGLE, 1'b0);
        chk(capacity_pct_o, 16'h0014);
        wr(`HVRB_ADR_CTRL_EN, 16'h00cb, `HVRB_FN_WRITE_SINGLE, 1'b0);
        tick(1);
        chk({12'h000, fan_behav_o}, 16'h000f);
        chk(fan_speed_o, 16'h0226);
        chk(capacity_pct_o, 16'h0046);
        ck1(heat_cmd_o, 1'b0);
        ck1(comp_cmd_o, 1'b1);
        sup_u.access(1'b0, `HVRB_ADR_MIN_RUN, 16'h0000, 8'h03);
        ck1(sup_u.q != 0 && sup_u.q <= 16'h0003, 1'b1);
        $display("test control example done");
        wr(`HVRB_ADR_COMP_REQ, 16'h0000, `HVRB_FN_WRITE_SINGLE, 1'b0);
        ck1(comp_cmd_o, 1'b1);
        for (i = 0; i < 40 && comp_cmd_o !== 1'b0; i++) tick(1);
        ck1(comp_cmd_o, 1'b0);
        sup_u.access(1'b0, `HVRB_ADR_MIN_OFF, 16'h0000, 8'h03);
        ck1(sup_u.q != 0, 1'b1);
        wr(`HVRB_ADR_COMP_REQ, 16'h0001, `HVRB_FN_WRITE_SINGLE, 1'b0);
        ck1(comp_cmd_o, 1'b0);
        wr(`HVRB_ADR_HEAT_REQ, 16'h0001, `HVRB_FN_WRITE_SINGLE, 1'b0);
        for (i = 0; i < 60 && heat_cmd_o !== 1'b1; i++) tick(1);
        ck1(heat_cmd_o, 1'b1);
        sup_u.access(1'b0, `HVRB_ADR_TO_COOL, 16'h0000, 8'h03);
        ck1(sup_u.q != 0 && sup_u.q <= HOLD_S, 1'b1);
        wr(`HVRB_ADR_HEAT_REQ, 16'h0000, `HVRB_FN_WRITE_SINGLE, 1'b0);
        ck1(heat_cmd_o, 1'b1);
        $display("test safety timers done");
        sup_u.block_write(16'h00cb, 16'h0000, 16'h0000, 16'h0005, 16'h03e8, 16'h0064, n_ok);
        chk(16'(n_ok), 16'h0009);
        rd(`HVRB_ADR_FAN_BEHAV, 16'h0005, 1'b0);
        wr(`HVRB_ADR_CTRL_EN, 16'hffff, `HVRB_FN_WRITE_MULTI, 1'b0);
        rd(`HVRB_ADR_CTRL_EN, `HVRB_EN_MASK, 1'b0);
        wr(`HVRB_ADR_CAP_REQ, 16'h0011, 8'h05, 1'b1);
        rd(`HVRB_ADR_CAP_REQ, 16'h0064, 1'b0);
        wr(`HVRB_ADR_MIN_RUN, 16'h0005, `HVRB_FN_WRITE_SINGLE, 1'b1);
        rd(16'h0300, 16'h0000, 1'b1);
        $display("test block write and refusals done");
        @(posedge ref_clk_i);
        protect_fan_i <= 1'b1;
        local_fan_behav_i <= 4'h2;
        tick(2);
        chk({12'h000, fan_behav_o}, 16'h0002);
        protect_fan_i <= 1'b0;
        $display("test protection done");
        for (n_ok = 0; n_ok < 6; n_ok++) begin
            @(posedge ref_clk_i);
            in_fan_speed_i <= (n_ok == 0) ? 16'h03e9 : 16'($urandom_range(1100));
            out_fan_speed_i <= 16'($urandom_range(1100));
            valve1_pos_i <= 16'($urandom_range(600));
            valve2_pos_i <= 16'($urandom_range(600));
            capacity_i <= (n_ok == 0) ? 16'hffff : 16'($urandom_range(1100));
            relays_i <= 9'($urandom_range(511));
            op_state_i <= 4'($urandom_range(12));
            #1;
            rd(`HVRB_ADR_IN_FAN_OUT, lim(in_fan_speed_i, `HVRB_SPEED_MAX), 1'b0);
            rd(`HVRB_ADR_OUT_FAN_OUT, lim(out_fan_speed_i, `HVRB_SPEED_MAX), 1'b0);
            rd(`HVRB_ADR_VALVE1_POS, lim(valve1_pos_i, `HVRB_VALVE_FULL_DEF), 1'b0);
            rd(`HVRB_ADR_VALVE2_POS, lim(valve2_pos_i, `HVRB_VALVE_FULL_DEF), 1'b0);
            rd(`HVRB_ADR_CAP_OUT, lim(capacity_i, `HVRB_CAP_OUT_MAX), 1'b0);
            rd(`HVRB_ADR_RELAYS, {7'h00, relays_i}, 1'b0);
            rd(`HVRB_ADR_OP_STATE, {12'h000, op_state_i}, 1'b0);
            rd(`HVRB_ADR_VALVE1_PCT, pct(valve1_pos_i), 1'b0);
            rd(`HVRB_ADR_VALVE2_PCT, pct(valve2_pos_i), 1'b0);
        end
        $display("test status words done");
        @(posedge ref_clk_i);
        rst_i <= 1'b1;
        tick(1);
        rst_i <= 1'b0;
        ck1(comp_cmd_o, 1'b0);
        rd(`HVRB_ADR_CTRL_EN, 16'h0000, 1'b0);
        $display("test power loss done");
        final_report;
    end
endmodule // tb
